// ==== dspl_defs.svh ====
// Register indices, field positions and reset values of the serial port.
`ifndef DSPL_DEFS_SVH
`define DSPL_DEFS_SVH

// ****************************************************************
// Register indices; the APB byte address is four times the index.
// ****************************************************************
`define DSPL_IDX_GLOBAL 24'h808040
`define DSPL_IDX_TX_PIN 24'h808042
`define DSPL_IDX_RX_PIN 24'h808043
`define DSPL_IDX_TMR_CTL 24'h808044
`define DSPL_IDX_TMR_CNT 24'h808045
`define DSPL_IDX_TMR_PER 24'h808046
`define DSPL_IDX_FLAG 24'h808047
`define DSPL_IDX_TX_BUF 24'h808048
`define DSPL_IDX_RX_BUF 24'h80804c

// ****************************************************************
// Field positions.
// ****************************************************************
`define DSPL_GC_TX_FREE 0
`define DSPL_GC_RX_FULL 1
`define DSPL_GC_RX_EN 2
`define DSPL_GC_TX_EN 6
`define DSPL_PC_CLK_OUT 0
`define DSPL_PC_FS_OUT 4
`define DSPL_TC_RUN 0
`define DSPL_FLAG_BIT 0

// ****************************************************************
// Reset values and word length.
// ****************************************************************
`define DSPL_RST_WORD 32'h00000000
`define DSPL_RST_FLAG 1'h1
`define DSPL_WORD_BITS 5'h10
`define DSPL_LAST_BIT 5'h0f

`endif

// ==== dspl_pkg.sv ====
// Types shared by the converter link serial port.
package dspl_pkg;

  // Transmit sequencer states.
  typedef enum logic [1:0] {
    DSPL_TX_IDLE = 2'b00,
    DSPL_TX_SYNC = 2'b01,
    DSPL_TX_SHIFT = 2'b10
  } dspl_tx_state_t;

  // Layout of one sixteen-bit converter word.
  typedef struct packed {
    logic reg_select_high;
    logic speed_select;
    logic power_down_bit;
    logic reg_select_low;
    logic [11:0] sample;
  } dspl_dac_word_t;

endpackage

// ==== dspl_serial_port.sv ====
// Serial port that shares one link between a serial ADC and a dual DAC.
//
// The APB register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "dspl_defs.svh"
module dspl_serial_port
  import dspl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_bit_clock_pin_i,
  output logic tx_bit_clock_pin_o,
  output logic tx_bit_clock_pin_oe,
  input wire logic tx_frame_sync_pin_i,
  output logic tx_frame_sync_pin_o,
  output logic tx_frame_sync_pin_oe,
  output logic tx_serial_pin,
  input wire logic rx_bit_clock_pin,
  input wire logic rx_frame_sync_pin,
  input wire logic rx_serial_pin,
  output logic flag_output_zero,
  output logic dac_select_n
);

  // ****************************************************************
  // APB slave.
  // ****************************************************************

  // Word index match; the two low address bits must be zero.
  function automatic logic reg_hit(input logic [31:0] a,
                                   input logic [23:0] idx);
    reg_hit = (a[31:26] == 6'h00) && (a[25:2] == idx) && (a[1:0] == 2'h0);
  endfunction

  logic [31:0] gc_reg, txpc_reg, rxpc_reg, tmc_reg, tcnt_reg, tper_reg;
  logic [31:0] txbuf_reg, rxbuf_reg, rx_shift_reg, tx_shift_reg;
  logic flag_reg, tx_free_reg, rx_full_reg, rx_pending_reg;
  logic pready_reg, pslverr_reg;
  logic [31:0] prdata_reg;
  logic apb_done, wr_en, rd_en, wr_txbuf, rd_rxbuf, mapped;

  // A transfer completes at the edge where pready is already high.
  assign apb_done = psel & penable & pready_reg;
  assign wr_en = apb_done & pwrite;
  assign rd_en = apb_done & ~pwrite;
  assign wr_txbuf = wr_en & reg_hit(paddr, `DSPL_IDX_TX_BUF);
  assign rd_rxbuf = rd_en & reg_hit(paddr, `DSPL_IDX_RX_BUF);
  assign mapped = reg_hit(paddr, `DSPL_IDX_GLOBAL) |
                  reg_hit(paddr, `DSPL_IDX_TX_PIN) |
                  reg_hit(paddr, `DSPL_IDX_RX_PIN) |
                  reg_hit(paddr, `DSPL_IDX_TMR_CTL) |
                  reg_hit(paddr, `DSPL_IDX_TMR_CNT) |
                  reg_hit(paddr, `DSPL_IDX_TMR_PER) |
                  reg_hit(paddr, `DSPL_IDX_FLAG) |
                  reg_hit(paddr, `DSPL_IDX_TX_BUF) |
                  reg_hit(paddr, `DSPL_IDX_RX_BUF);

  // One wait state keeps read data and error straight from flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= `DSPL_RST_WORD;
    end else begin
      pready_reg <= psel & penable & ~pready_reg;
      pslverr_reg <= psel & penable & ~pready_reg & ~mapped;
      prdata_reg <= `DSPL_RST_WORD;
      if (psel & penable & ~pready_reg & ~pwrite) begin
        if (reg_hit(paddr, `DSPL_IDX_GLOBAL)) begin
          prdata_reg <= {gc_reg[31:2], rx_full_reg, tx_free_reg};
        end
        if (reg_hit(paddr, `DSPL_IDX_TX_PIN)) prdata_reg <= txpc_reg;
        if (reg_hit(paddr, `DSPL_IDX_RX_PIN)) prdata_reg <= rxpc_reg;
        if (reg_hit(paddr, `DSPL_IDX_TMR_CTL)) prdata_reg <= tmc_reg;
        if (reg_hit(paddr, `DSPL_IDX_TMR_CNT)) prdata_reg <= tcnt_reg;
        if (reg_hit(paddr, `DSPL_IDX_TMR_PER)) prdata_reg <= tper_reg;
        if (reg_hit(paddr, `DSPL_IDX_FLAG)) begin
          prdata_reg <= {31'h00000000, flag_reg};
        end
        if (reg_hit(paddr, `DSPL_IDX_TX_BUF)) prdata_reg <= txbuf_reg;
        if (reg_hit(paddr, `DSPL_IDX_RX_BUF)) prdata_reg <= rxbuf_reg;
      end
    end
  end

  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;

  // Control registers; status bits of the global word are not stored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gc_reg <= `DSPL_RST_WORD;
      txpc_reg <= `DSPL_RST_WORD;
      rxpc_reg <= `DSPL_RST_WORD;
      tmc_reg <= `DSPL_RST_WORD;
      tper_reg <= `DSPL_RST_WORD;
      txbuf_reg <= `DSPL_RST_WORD;
      flag_reg <= `DSPL_RST_FLAG;
    end else if (wr_en) begin
      if (reg_hit(paddr, `DSPL_IDX_GLOBAL)) gc_reg <= {pwdata[31:2], 2'h0};
      if (reg_hit(paddr, `DSPL_IDX_TX_PIN)) txpc_reg <= pwdata;
      if (reg_hit(paddr, `DSPL_IDX_RX_PIN)) rxpc_reg <= pwdata;
      if (reg_hit(paddr, `DSPL_IDX_TMR_CTL)) tmc_reg <= pwdata;
      if (reg_hit(paddr, `DSPL_IDX_TMR_PER)) tper_reg <= pwdata;
      if (reg_hit(paddr, `DSPL_IDX_FLAG)) begin
        flag_reg <= pwdata[`DSPL_FLAG_BIT];
      end
      if (wr_txbuf) txbuf_reg <= pwdata;
    end
  end

  // Flag low selects the ADC; the flop drives the pin directly.
  assign flag_output_zero = flag_reg;

  // ****************************************************************
  // Bit clock generation and pin synchronisers.
  // ****************************************************************
  logic bit_clk_reg, tmr_hit, clk_out_mode, fs_out_mode;
  logic txclk_s1, txclk_s2, txclk_s3, txfs_s1, txfs_s2;
  logic rxclk_s1, rxclk_s2, rxclk_s3, rxfs_s1, rxfs_s2, rxd_s1, rxd_s2;
  logic tx_rise, rx_fall;

  assign clk_out_mode = txpc_reg[`DSPL_PC_CLK_OUT];
  assign fs_out_mode = txpc_reg[`DSPL_PC_FS_OUT];
  assign tmr_hit = tmc_reg[`DSPL_TC_RUN] & (tcnt_reg == tper_reg);

  // Half bit period is period+1 pclk cycles; the counter is writable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcnt_reg <= `DSPL_RST_WORD;
      bit_clk_reg <= 1'b0;
    end else begin
      if (wr_en && reg_hit(paddr, `DSPL_IDX_TMR_CNT)) begin
        tcnt_reg <= pwdata;
      end else if (tmr_hit) begin
        tcnt_reg <= `DSPL_RST_WORD;
      end else if (tmc_reg[`DSPL_TC_RUN]) begin
        tcnt_reg <= tcnt_reg + 32'h00000001;
      end
      if (tmr_hit) bit_clk_reg <= ~bit_clk_reg;
    end
  end

  // Pin direction follows the pin control word.
  assign tx_bit_clock_pin_o = bit_clk_reg;
  assign tx_bit_clock_pin_oe = clk_out_mode;

  // Two flops ahead of any logic; the third only keeps edge history.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {txclk_s1, txclk_s2, txclk_s3, txfs_s1, txfs_s2} <= 5'h00;
      {rxclk_s1, rxclk_s2, rxclk_s3, rxfs_s1, rxfs_s2} <= 5'h00;
      {rxd_s1, rxd_s2} <= 2'h0;
    end else begin
      txclk_s1 <= tx_bit_clock_pin_i;
      txclk_s2 <= txclk_s1;
      txclk_s3 <= txclk_s2;
      txfs_s1 <= tx_frame_sync_pin_i;
      txfs_s2 <= txfs_s1;
      rxclk_s1 <= rx_bit_clock_pin;
      rxclk_s2 <= rxclk_s1;
      rxclk_s3 <= rxclk_s2;
      rxfs_s1 <= rx_frame_sync_pin;
      rxfs_s2 <= rxfs_s1;
      rxd_s1 <= rx_serial_pin;
      rxd_s2 <= rxd_s1;
    end
  end

  // The internal clock needs no synchroniser, so its edge is known early.
  assign tx_rise = clk_out_mode ? (tmr_hit & ~bit_clk_reg) :
                                  (txclk_s2 & ~txclk_s3);
  assign rx_fall = rxclk_s3 & ~rxclk_s2;

  // ****************************************************************
  // Transmit path.
  // ****************************************************************
  dspl_tx_state_t tx_state_reg;
  dspl_dac_word_t tx_word;
  logic [4:0] tx_cnt_reg;
  logic tx_fs_reg, tx_data_reg, dac_sel_n_reg, tx_load;

  assign tx_word = dspl_dac_word_t'(txbuf_reg[15:0]);
  // A buffer write in the same cycle defers the load by one bit clock.
  assign tx_load = tx_rise & (tx_state_reg == DSPL_TX_IDLE) &
                   gc_reg[`DSPL_GC_TX_EN] & ~tx_free_reg & ~wr_txbuf;

  // Sync pulse one bit wide, then sixteen bits MSB first; each word is
  // framed alone, so software orders init, config and select words.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_reg <= DSPL_TX_IDLE;
      tx_cnt_reg <= 5'h00;
      tx_shift_reg <= `DSPL_RST_WORD;
      tx_fs_reg <= 1'b0;
      tx_data_reg <= 1'b0;
      dac_sel_n_reg <= 1'b1;
    end else if (tx_rise) begin
      case (tx_state_reg)
        DSPL_TX_IDLE: begin
          if (tx_load) begin
            tx_shift_reg <= {16'h0000, tx_word};
            tx_fs_reg <= fs_out_mode;
            dac_sel_n_reg <= ~flag_reg;
            tx_state_reg <= DSPL_TX_SYNC;
          end
        end
        DSPL_TX_SYNC: begin
          if (fs_out_mode || txfs_s2) begin
            tx_fs_reg <= 1'b0;
            tx_data_reg <= tx_shift_reg[15];
            tx_shift_reg <= {tx_shift_reg[30:0], 1'b0};
            tx_cnt_reg <= 5'h01;
            tx_state_reg <= DSPL_TX_SHIFT;
          end
        end
        DSPL_TX_SHIFT: begin
          if (tx_cnt_reg == `DSPL_WORD_BITS) begin
            dac_sel_n_reg <= 1'b1;
            tx_state_reg <= DSPL_TX_IDLE;
          end else begin
            tx_data_reg <= tx_shift_reg[15];
            tx_shift_reg <= {tx_shift_reg[30:0], 1'b0};
            tx_cnt_reg <= tx_cnt_reg + 5'h01;
          end
        end
        default: tx_state_reg <= DSPL_TX_IDLE;
      endcase
    end
  end

  // Free flag: set by the load, cleared by a buffer write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_free_reg <= 1'b1;
    end else if (tx_load) begin
      tx_free_reg <= 1'b1;
    end else if (wr_txbuf) begin
      tx_free_reg <= 1'b0;
    end
  end

  assign tx_frame_sync_pin_o = tx_fs_reg;
  assign tx_frame_sync_pin_oe = fs_out_mode;
  assign tx_serial_pin = tx_data_reg;
  assign dac_select_n = dac_sel_n_reg;

  // ****************************************************************
  // Receive path.
  // ****************************************************************
  logic rx_busy_reg, rx_done;
  logic [4:0] rx_cnt_reg;
  logic [15:0] rx_word;

  assign rx_done = rx_fall & rx_busy_reg & ~rx_pending_reg &
                   (rx_cnt_reg == `DSPL_LAST_BIT);
  assign rx_word = {rx_shift_reg[14:0], rxd_s2};

  // A sync seen at a falling edge arms capture of the next sixteen bits;
  // while a word waits for an unread buffer every edge is ignored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_busy_reg <= 1'b0;
      rx_cnt_reg <= 5'h00;
      rx_shift_reg <= `DSPL_RST_WORD;
    end else if (rx_fall && !rx_pending_reg && gc_reg[`DSPL_GC_RX_EN]) begin
      if (!rx_busy_reg) begin
        rx_busy_reg <= rxfs_s2;
        rx_cnt_reg <= 5'h00;
      end else begin
        rx_shift_reg <= {rx_shift_reg[30:0], rxd_s2};
        rx_cnt_reg <= rx_cnt_reg + 5'h01;
        if (rx_cnt_reg == `DSPL_LAST_BIT) rx_busy_reg <= 1'b0;
      end
    end
  end

  // Buffer and flags; a completing word wins over a clearing read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxbuf_reg <= `DSPL_RST_WORD;
      rx_full_reg <= 1'b0;
      rx_pending_reg <= 1'b0;
    end else if (rx_done) begin
      if (!rx_full_reg || rd_rxbuf) begin
        rxbuf_reg <= {16'h0000, rx_word};
        rx_full_reg <= 1'b1;
      end else begin
        rx_pending_reg <= 1'b1;
      end
    end else if (rd_rxbuf) begin
      if (rx_pending_reg) begin
        rxbuf_reg <= {16'h0000, rx_shift_reg[15:0]};
        rx_pending_reg <= 1'b0;
      end else begin
        rx_full_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [4:0] h_bits;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_bits <= 5'h00;
    end else if (tx_rise && tx_state_reg == DSPL_TX_SYNC) begin
      h_bits <= 5'h00;
    end else if (tx_rise && tx_state_reg == DSPL_TX_SHIFT) begin
      h_bits <= h_bits + 5'h01;
    end
  end

  property p_flag_write;
    wr_en && reg_hit(paddr, `DSPL_IDX_FLAG) |=>
      flag_output_zero == $past(pwdata[0]);
  endproperty
  a_flag_write: assert property (p_flag_write)
    else $error("flag output did not follow its register write");

  property p_sync_pulse;
    $rose(tx_frame_sync_pin_o) |-> tx_frame_sync_pin_oe &&
      tx_state_reg == DSPL_TX_SYNC;
  endproperty
  a_sync_pulse: assert property (p_sync_pulse)
    else $error("frame sync rose outside a word start");

  property p_sixteen_bits;
    tx_state_reg == DSPL_TX_SHIFT ##1 tx_state_reg == DSPL_TX_IDLE |->
      h_bits == `DSPL_WORD_BITS;
  endproperty
  a_sixteen_bits: assert property (p_sixteen_bits)
    else $error("word did not span sixteen bit clocks");

  property p_free_on_load;
    $rose(tx_free_reg) |-> $past(tx_load) && $past(tx_state_reg) ==
      DSPL_TX_IDLE;
  endproperty
  a_free_on_load: assert property (p_free_on_load)
    else $error("buffer flagged free without a load");

  property p_frozen;
    rx_pending_reg && !rd_rxbuf |=> rx_pending_reg &&
      $stable(rxbuf_reg) && $stable(rx_shift_reg);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("receiver moved while frozen");

  property p_clock_dir;
    wr_en && reg_hit(paddr, `DSPL_IDX_TX_PIN) |=>
      tx_bit_clock_pin_oe == $past(pwdata[0]) &&
      tx_frame_sync_pin_oe == $past(pwdata[4]);
  endproperty
  a_clock_dir: assert property (p_clock_dir)
    else $error("pin direction did not follow pin control");

  property p_dac_gate;
    !dac_select_n |-> flag_output_zero && tx_state_reg != DSPL_TX_IDLE;
  endproperty
  a_dac_gate: assert property (p_dac_gate)
    else $error("DAC selected outside a flagged frame");

  property p_rx_word;
    rx_done && !rx_full_reg |=> rx_full_reg &&
      rxbuf_reg[15:0] == $past(rx_word);
  endproperty
  a_rx_word: assert property (p_rx_word)
    else $error("received word not moved to buffer");

  property p_unmapped;
    psel && penable && !pready_reg && !mapped |=> pready && pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not answered with an error");

  property p_data_moves;
    $changed(tx_serial_pin) |-> $past(tx_rise);
  endproperty
  a_data_moves: assert property (p_data_moves)
    else $error("transmit data changed off a bit clock edge");

endmodule
`default_nettype wire

// ==== dspl_conv_model.sv ====
// Behavioural serial ADC and dual DAC that share the port's link.
`timescale 1ns/1ns
`default_nettype none
module dspl_conv_model (
  input wire logic sclk,
  input wire logic fs,
  input wire logic adc_serial_in,
  input wire logic adc_cs_n,
  input wire logic dac_cs_n,
  input wire logic [15:0] result,
  output logic adc_serial_out,
  output logic int_n,
  output logic [15:0] adc_word,
  output logic [15:0] dac_word,
  output int adc_n,
  output int dac_n
);
  int ac = 0;
  int dc = 0;
  logic act = 1'b0;
  logic [15:0] sh = 16'h0;
  logic [15:0] dsh = 16'h0;
  logic [11:0] cfg;
  logic [11:0] dac_a;
  logic [11:0] dac_b;
  logic [11:0] dac_buf;

  initial begin
    adc_serial_out = 1'b0;
    int_n = 1'b1;
    adc_word = 16'h0;
    dac_word = 16'h0;
    adc_n = 0;
    dac_n = 0;
  end

  // ADC: a sync seen at a fall while selected opens a frame of 16 falls.
  always @(negedge sclk) begin
    if (act) begin
      sh = {sh[14:0], adc_serial_in};
      ac++;
      if (ac == 16) begin
        act = 1'b0;
        adc_word = sh;
        adc_n++;
        int_n = 1'b0;
        if (sh[15:12] == 4'ha) cfg = sh[11:0];
      end
    end else if (fs && !adc_cs_n) begin
      act = 1'b1;
      ac = 0;
    end
  end

  // Result bits leave on rises; an idle line toggles to expose stale bits.
  always @(posedge sclk) begin
    if (act && !adc_cs_n) adc_serial_out = result[15 - ac];
    else adc_serial_out = ~adc_serial_out;
  end

  // The first falling select or sync withdraws the interrupt.
  always @(negedge fs or negedge adc_cs_n) int_n = 1'b1;

  // DAC: shifts while selected and keeps the last 16 bits when select rises.
  always @(negedge sclk) begin
    if (!dac_cs_n) begin
      dsh = {dsh[14:0], adc_serial_in};
      dc++;
    end
  end

  // Register-select decode; code 11 is reserved and changes nothing.
  always @(posedge dac_cs_n) begin
    if (dc >= 16) begin
      dac_word = dsh;
      dac_n++;
      case ({dsh[15], dsh[12]})
        2'b00: begin
          dac_b = dsh[11:0];
          dac_buf = dsh[11:0];
        end
        2'b01: dac_buf = dsh[11:0];
        2'b10: begin
          dac_a = dsh[11:0];
          dac_b = dac_buf;
        end
        default: dac_buf = dac_buf;
      endcase
    end
    dc = 0;
  end
endmodule
`default_nettype wire

// ==== dsp_serial_port_converter_link_tb.sv ====
// Self-checking bench for the converter link serial port.
`timescale 1ns/1ns
`default_nettype none
`include "dspl_defs.svh"
module dsp_serial_port_converter_link_tb;
  import dspl_pkg::*;
  // ****************************************
  // Signals and design.
  // ****************************************
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [31:0] paddr, pwdata, prdata, r, rnd;
  logic clk_o, clk_oe, fs_o, fs_oe, tx_d, flag, dsel_n, adc_serial_out, int_n;
  logic ext_clk, ext_en;
  logic [15:0] res, adc_w, dac_w;
  logic [11:0] sa;
  logic [15:0] rxq[$];
  dspl_dac_word_t dw;
  int adc_cnt, dac_cnt, n_errors, compares, cyc, n0;
  wire logic clk_net;
  wire logic fs_net;
  // A released clock pin idles low; an outside sync stays high while the
  // outside clock runs, so a released sync line never stalls a word.
  assign clk_net = clk_oe ? clk_o : ext_clk;
  assign fs_net = fs_oe ? fs_o : ext_en;

  dspl_serial_port dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_bit_clock_pin_i(clk_net), .tx_bit_clock_pin_o(clk_o),
    .tx_bit_clock_pin_oe(clk_oe), .tx_frame_sync_pin_i(fs_net),
    .tx_frame_sync_pin_o(fs_o), .tx_frame_sync_pin_oe(fs_oe),
    .tx_serial_pin(tx_d), .rx_bit_clock_pin(clk_net),
    .rx_frame_sync_pin(fs_net), .rx_serial_pin(adc_serial_out),
    .flag_output_zero(flag), .dac_select_n(dsel_n));

  dspl_conv_model conv (.sclk(clk_net), .fs(fs_net), .adc_serial_in(tx_d),
    .adc_cs_n(flag), .dac_cs_n(dsel_n), .result(res), .adc_serial_out(adc_serial_out),
    .int_n(int_n), .adc_word(adc_w), .dac_word(dac_w), .adc_n(adc_cnt),
    .dac_n(dac_cnt));

  // Core clock, and an 80 ns link clock offset so no edge meets pclk.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    ext_clk = 1'b0;
    #1;
    forever #40 ext_clk = ext_en ? ~ext_clk : 1'b0;
  end

  // ****************************************
  // Tasks.
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] %0t reg got %h exp %h", $time, g, x);
    end
  endtask

  task automatic chkw(input logic [15:0] g, input logic [15:0] x);
    compares++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] %0t word got %h exp %h", $time, g, x);
    end
  endtask

  // Holds the request until pready is sampled high, then releases.
  task automatic apb(input logic w, input logic [23:0] i,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {6'h0, i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // The write lands at the last edge of the transfer; one more edge lets
  // it settle before any pin is compared.
  task automatic wr(input logic [23:0] i, input logic [31:0] d);
    apb(1'b1, i, d);
    @(posedge pclk);
  endtask

  task automatic rd(input logic [23:0] i, input logic [31:0] x);
    apb(1'b0, i, 32'h0);
    chk(r, x);
  endtask

  // Waits for the full flag, then takes the oldest expected result.
  task automatic rx_read();
    do apb(1'b0, `DSPL_IDX_GLOBAL, 32'h0); while (r[1] !== 1'b1);
    apb(1'b0, `DSPL_IDX_RX_BUF, 32'h0);
    chk(r, {16'h0, rxq.pop_front()});
  endtask

  task automatic adc_xfer(input logic [15:0] w, input logic [15:0] rs);
    int n;
    n = adc_cnt;
    res <= rs;
    rxq.push_back(rs);
    wr(`DSPL_IDX_TX_BUF, {16'h0, w});
    while (adc_cnt == n) @(posedge pclk);
    chkw(adc_w, w);
    chkw({15'h0, int_n}, 16'h0);
  endtask

  task automatic dac_xfer(input logic [15:0] w);
    int n;
    n = dac_cnt;
    wr(`DSPL_IDX_TX_BUF, {16'h0, w});
    while (dac_cnt == n) @(posedge pclk);
    chkw(dac_w, w);
  endtask

  task automatic wrap_up();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // A hung handshake or frame ends the run as a mismatch.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    {presetn, psel, penable, pwrite, ext_en} = 5'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    res = 16'h0;
    rnd = 32'hfc64a28a;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({28'h0, flag, dsel_n, clk_oe, fs_oe}, 32'hc);
    rd(`DSPL_IDX_GLOBAL, 32'h1);
    rd(`DSPL_IDX_FLAG, 32'h1);
    rd(`DSPL_IDX_TMR_PER, 32'h0);
    apb(1'b0, 24'h808041, 32'h0);
    chk({r[31:1], e}, 32'h1);
    wr(`DSPL_IDX_TX_PIN, 32'h111);
    wr(`DSPL_IDX_RX_PIN, 32'h111);
    wr(`DSPL_IDX_TMR_PER, 32'h9);
    wr(`DSPL_IDX_TMR_CTL, 32'h1cf);
    wr(`DSPL_IDX_GLOBAL, 32'h0c140044);
    wr(`DSPL_IDX_RX_BUF, 32'h1234);
    rd(`DSPL_IDX_RX_BUF, 32'h0);
    rd(`DSPL_IDX_RX_PIN, 32'h111);
    wr(`DSPL_IDX_FLAG, 32'h0);
    chk({29'h0, clk_oe, fs_oe, flag}, 32'h6);
    // Setup word, configuration with command A, select, then a conversion.
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      adc_xfer({(i == 1) ? 4'ha : rnd[31:28], rnd[11:0]}, rnd[27:12]);
      rx_read();
    end
    apb(1'b0, `DSPL_IDX_GLOBAL, 32'h0);
    chk(r & 32'h47, 32'h45);
    // Two words back to back; the second result waits behind an unread one.
    rnd = lfsr(rnd);
    n0 = adc_cnt;
    res <= rnd[31:16];
    rxq.push_back(rnd[31:16]);
    wr(`DSPL_IDX_TX_BUF, {16'h0, rnd[15:0]});
    // Software waits for the free flag before it refills the buffer.
    do apb(1'b0, `DSPL_IDX_GLOBAL, 32'h0); while (r[0] !== 1'b1);
    wr(`DSPL_IDX_TX_BUF, {16'h0, ~rnd[15:0]});
    apb(1'b0, `DSPL_IDX_GLOBAL, 32'h0);
    chk(r & 32'h1, 32'h0);
    while (adc_cnt == n0) @(posedge pclk);
    res <= ~rnd[31:16];
    rxq.push_back(~rnd[31:16]);
    chkw(adc_w, rnd[15:0]);
    while (adc_cnt == n0 + 1) @(posedge pclk);
    chkw(adc_w, ~rnd[15:0]);
    rx_read();
    rx_read();
    // DAC words with register-select codes 00, 01, 10 and 00 again, the last on an outside clock.
    wr(`DSPL_IDX_GLOBAL, 32'h40);
    wr(`DSPL_IDX_FLAG, 32'h1);
    n0 = adc_cnt;
    for (int c = 0; c < 4; c++) begin
      if (c == 3) begin
        wr(`DSPL_IDX_TX_PIN, 32'h100);
        ext_en <= 1'b1;
        chk({30'h0, clk_oe, fs_oe}, 32'h0);
      end
      rnd = lfsr(rnd);
      dw = rnd[15:0];
      dw.reg_select_high = (c == 2);
      dw.reg_select_low = (c == 1);
      if (c == 2) sa = dw.sample;
      dac_xfer(dw);
    end
    ext_en <= 1'b0;
    chk(32'(adc_cnt), 32'(n0));
    chkw({4'h0, conv.dac_a}, {4'h0, sa});
    chkw({4'h0, conv.dac_b}, {4'h0, dw.sample});
    wrap_up();
  end
endmodule
`default_nettype wire
